//--- shared/rx_stat_pkg.sv
// Purpose: Shared constants for the receive statistics counter bank.
// Assumes: Register addresses are word indices on a plain register port.
// Notes:   Counter slots are indexed by the IDX_ constants.
`default_nettype none
package rx_stat_pkg;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int CNT_W    = 64;
    localparam int LEN_W    = 16;
    localparam int NUM_CNT  = 3;
    localparam int IDX_RUNT = 0;
    localparam int IDX_OVER = 1;
    localparam int IDX_FCS  = 2;

    localparam logic [ADDR_W-1:0] ADDR_RUNT_LOW  = 12'h900;
    localparam logic [ADDR_W-1:0] ADDR_RUNT_HIGH = 12'h901;
    localparam logic [ADDR_W-1:0] ADDR_OVER_LOW  = 12'h902;
    localparam logic [ADDR_W-1:0] ADDR_FCS_LOW   = 12'h904;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL   = 12'h945;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 12'h946;

    localparam int CTRL_CLEAR_BIT  = 0;
    localparam int CTRL_SHADOW_BIT = 2;
    localparam int STAT_PAUSED_BIT = 1;

    localparam logic               SHADOW_RESET = 1'h0;
    localparam logic [CNT_W-1:0]   COUNT_RESET  = 64'h0;
    localparam logic [DATA_W-1:0]  READ_IDLE    = 32'h0;

    // Frame length in bytes counted from destination address through CRC.
    localparam logic [LEN_W-1:0] RUNT_LIMIT     = 16'h0040;
    localparam logic [LEN_W-1:0] OVERSIZE_LIMIT = 16'h05ee;
endpackage
`default_nettype wire

//--- core/stat_counter64.sv
// Purpose: One wrapping 64-bit event counter with a host-visible snapshot.
// Assumes: Increment and clear come from logic on the same clock.
// Notes:   Clear wins over increment and also clears the snapshot.
`timescale 1ns/100ps
`default_nettype none
module stat_counter64
    import rx_stat_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             inc,
    input  wire logic             clear,
    input  wire logic             freeze,
    output logic      [CNT_W-1:0] count,
    output logic      [CNT_W-1:0] visible
);
    logic [CNT_W-1:0] next_count;

    always_comb begin
        next_count = count + 64'h1;
    end

    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            count <= COUNT_RESET;
        end else if (inc) begin
            count <= next_count;
        end
    end

    // The snapshot tracks the live count until frozen, so reads taken while frozen never tear.
    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            visible <= COUNT_RESET;
        end else if (!freeze) begin
            visible <= inc ? next_count : count;
        end
    end

    AST_CNT_STEP: assert property (@(posedge clock) disable iff (!rst_n)
        inc && !clear |=> count == $past(count) + 64'h1)
        else $error("counter did not step by one");
    AST_CNT_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
        inc && !clear && (&count) |=> count == 64'h0)
        else $error("counter did not wrap to zero");
    AST_CNT_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        clear |=> count == 64'h0 && visible == 64'h0)
        else $error("clear did not zero the counter");
    AST_CNT_FROZEN: assert property (@(posedge clock) disable iff (!rst_n)
        freeze && !clear ##1 freeze && !clear |-> $stable(visible))
        else $error("snapshot moved while frozen");
endmodule
`default_nettype wire

//--- core/frame_length_classifier.sv
// Purpose: Turns frame-end reports into runt and oversize CRC-error pulses.
// Assumes: frame_len counts destination address, source address, data and CRC.
// Notes:   Outputs are registered one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module frame_length_classifier
    import rx_stat_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             frame_done,
    input  wire logic [LEN_W-1:0] frame_len,
    input  wire logic             crc_error,
    output logic                  runt_hit,
    output logic                  oversize_hit
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            runt_hit <= 1'b0;
        end else begin
            runt_hit <= frame_done && crc_error && (frame_len < RUNT_LIMIT);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            oversize_hit <= 1'b0;
        end else begin
            oversize_hit <= frame_done && crc_error && (frame_len > OVERSIZE_LIMIT);
        end
    end

    AST_RUNT_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
        frame_done && crc_error && frame_len == 16'h003f |=> runt_hit)
        else $error("63-byte errored frame not flagged as runt");
    AST_RUNT_EDGE: assert property (@(posedge clock) disable iff (!rst_n)
        frame_done && frame_len == 16'h0040 |=> !runt_hit)
        else $error("64-byte frame flagged as runt");
    AST_OVER_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
        oversize_hit |-> $past(frame_done && crc_error && frame_len > 16'h05ee))
        else $error("oversize pulse without an oversized errored frame");
endmodule
`default_nettype wire

//--- core/rx_statistics_counter_bank.sv
// Purpose: Receive statistics counter bank with snapshot and clear-all control.
// Assumes: Event inputs come from receive logic on the same clock as the register port.
// Notes:   Addresses are word indices; read data appear one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module rx_statistics_counter_bank
    import rx_stat_pkg::*;
#(
    parameter bit ENABLE_RX_STATS = 1'b1
)
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic              frame_done,
    input  wire logic [LEN_W-1:0]  frame_len,
    input  wire logic              crc_error,
    input  wire logic              fcs_error,
    output logic                   stats_paused
);
    logic                  shadow;
    logic                  clear_all;
    logic                  runt_hit;
    logic                  oversize_hit;
    logic [NUM_CNT-1:0]    events;
    logic [CNT_W-1:0]      live    [NUM_CNT];
    logic [CNT_W-1:0]      visible [NUM_CNT];
    logic [DATA_W-1:0]     next_rd_data;
    logic                  wr_control;

    assign wr_control = wr_en && (addr == ADDR_CONTROL);

    // Shadow request bit, held until software writes it back to zero.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shadow <= SHADOW_RESET;
        end else if (wr_control) begin
            shadow <= wr_data[CTRL_SHADOW_BIT];
        end
    end

    // Clear-all is self-clearing: one pulse on the cycle after the write.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clear_all <= 1'b0;
        end else begin
            clear_all <= wr_control && wr_data[CTRL_CLEAR_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stats_paused <= 1'b0;
        end else begin
            stats_paused <= shadow;
        end
    end

    frame_length_classifier u_classifier (
        .clock        (clock),
        .rst_n        (rst_n),
        .frame_done   (frame_done),
        .frame_len    (frame_len),
        .crc_error    (crc_error),
        .runt_hit     (runt_hit),
        .oversize_hit (oversize_hit)
    );

    always_comb begin
        events           = '0;
        events[IDX_RUNT] = runt_hit;
        events[IDX_OVER] = oversize_hit;
        events[IDX_FCS]  = fcs_error;
    end

    generate
        if (ENABLE_RX_STATS) begin : g_stats
            for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
                stat_counter64 u_counter (
                    .clock   (clock),
                    .rst_n   (rst_n),
                    .inc     (events[i]),
                    .clear   (clear_all),
                    .freeze  (shadow),
                    .count   (live[i]),
                    .visible (visible[i])
                );
            end
        end else begin : g_no_stats
            // No counters are built, so every counter address reads as zero.
            for (genvar i = 0; i < NUM_CNT; i++) begin : g_zero
                assign live[i]    = COUNT_RESET;
                assign visible[i] = COUNT_RESET;
            end
        end
    endgenerate

    // Read decode; the counter values shown are the snapshot path only.
    always_comb begin
        next_rd_data = READ_IDLE;
        unique case (addr)
            ADDR_RUNT_LOW:  next_rd_data = visible[IDX_RUNT][31:0];
            ADDR_RUNT_HIGH: next_rd_data = visible[IDX_RUNT][63:32];
            ADDR_OVER_LOW:  next_rd_data = visible[IDX_OVER][31:0];
            ADDR_FCS_LOW:   next_rd_data = visible[IDX_FCS][31:0];
            ADDR_CONTROL:   next_rd_data[CTRL_SHADOW_BIT] = shadow;
            ADDR_STATUS:    next_rd_data[STAT_PAUSED_BIT] = stats_paused;
            default:        next_rd_data = READ_IDLE;
        endcase
    end

    // Read data stand only in the cycle after the strobe; reads have no side effect.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= READ_IDLE;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= READ_IDLE;
        end
    end

    AST_READ_NO_EFFECT: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && !wr_en && events == 3'h0 && !clear_all
        |=> live[IDX_RUNT] == $past(live[IDX_RUNT])
            && live[IDX_OVER] == $past(live[IDX_OVER])
            && live[IDX_FCS] == $past(live[IDX_FCS]))
        else $error("read changed a counter");

    AST_FCS_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
        ENABLE_RX_STATS && fcs_error && !clear_all
        |=> live[IDX_FCS] == $past(live[IDX_FCS]) + 64'h1)
        else $error("checksum error pulse not counted once");

    AST_RUNT_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
        ENABLE_RX_STATS && frame_done && crc_error && frame_len < 16'h0040
        ##1 !clear_all |=> live[IDX_RUNT] == $past(live[IDX_RUNT]) + 64'h1)
        else $error("errored runt frame not counted");

    AST_OVER_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
        ENABLE_RX_STATS && oversize_hit && !clear_all
        |=> live[IDX_OVER] == $past(live[IDX_OVER]) + 64'h1)
        else $error("errored oversize frame not counted");

    AST_CLEAR_ALL: assert property (@(posedge clock) disable iff (!rst_n)
        wr_control && wr_data[CTRL_CLEAR_BIT]
        |=> clear_all ##1 (live[IDX_RUNT] == 64'h0 && live[IDX_OVER] == 64'h0
            && live[IDX_FCS] == 64'h0))
        else $error("clear-all did not zero all counters");

    AST_CLEAR_SELF: assert property (@(posedge clock) disable iff (!rst_n)
        clear_all |=> !clear_all || $past(wr_control && wr_data[CTRL_CLEAR_BIT]))
        else $error("clear bit did not self-clear");

    AST_SHADOW_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == ADDR_FCS_LOW && shadow && !clear_all
        ##1 rd_en && addr == ADDR_FCS_LOW && shadow && !clear_all
        |=> rd_data == $past(rd_data))
        else $error("snapshot value changed between frozen reads");

    AST_LIVE_VIEW: assert property (@(posedge clock) disable iff (!rst_n)
        rd_en && addr == ADDR_RUNT_HIGH && !shadow && !$past(shadow)
        |=> rd_data == live[IDX_RUNT][63:32] || $past(events[IDX_RUNT]) || $past(clear_all))
        else $error("unfrozen read did not show the live count");

    AST_DISABLED_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        !ENABLE_RX_STATS && rd_en
        && (addr == ADDR_RUNT_LOW || addr == ADDR_RUNT_HIGH
            || addr == ADDR_OVER_LOW || addr == ADDR_FCS_LOW)
        |=> rd_data == 32'h0)
        else $error("disabled bank returned nonzero counter data");

    AST_READ_ONE_CYCLE: assert property (@(posedge clock) disable iff (!rst_n)
        !rd_en |=> rd_data == 32'h0)
        else $error("read data outside the answer cycle");

    COV_RUNT_READ: cover property (@(posedge clock) disable iff (!rst_n)
        runt_hit ##[1:20] rd_en && addr == ADDR_RUNT_LOW);
    COV_SNAPSHOT: cover property (@(posedge clock) disable iff (!rst_n)
        shadow && fcs_error ##[1:20] rd_en && addr == ADDR_FCS_LOW);
    COV_CLEAR: cover property (@(posedge clock) disable iff (!rst_n)
        clear_all && events != 3'h0);
    COV_OVERSIZE: cover property (@(posedge clock) disable iff (!rst_n)
        oversize_hit);
endmodule
`default_nettype wire

//--- test/rx_event_source.sv
// Purpose: Stand-in for the receive datapath that emits frame-end and checksum pulses.
// Assumes: Each task is called from the bench just after a rising edge.
// Notes:   Length and crc_error lines carry inverted junk between frames.
`timescale 1ns/100ps
`default_nettype none
module rx_event_source
    import rx_stat_pkg::*;
(
    input  wire logic             clock,
    output logic                  frame_done,
    output logic      [LEN_W-1:0] frame_len,
    output logic                  crc_error,
    output logic                  fcs_error
);
    initial begin
        frame_done = 1'b0;
        frame_len  = 16'h0;
        crc_error  = 1'b0;
        fcs_error  = 1'b0;
    end

    task automatic send_frame(input logic [LEN_W-1:0] data_len, input logic crc);
        @(posedge clock);
        frame_done <= 1'b1;
        frame_len  <= 16'h000c + data_len + 16'h0004;
        crc_error  <= crc;
        @(posedge clock);
        frame_done <= 1'b0;
        frame_len  <= ~(16'h000c + data_len + 16'h0004);
        crc_error  <= ~crc;
    endtask

    task automatic pulse_fcs(input int n);
        @(posedge clock);
        fcs_error <= 1'b1;
        repeat (n) @(posedge clock);
        fcs_error <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/rx_statistics_counter_bank_tb.sv
// Purpose: Self-checking bench for the receive statistics counter bank.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   A second bank built without statistics must read zero at every counter address.
`timescale 1ns/100ps
`default_nettype none
module rx_statistics_counter_bank_tb
    import rx_stat_pkg::*;
;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = 12'h0;
    logic [DATA_W-1:0] wr_data = 32'h0;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] rd_data_off;
    logic              frame_done;
    logic [LEN_W-1:0]  frame_len;
    logic              crc_error;
    logic              fcs_error;
    logic              stats_paused;
    logic [CNT_W-1:0]  exp [NUM_CNT];
    logic [CNT_W-1:0]  snap [NUM_CNT];
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] v2;
    int                err_total = 0;
    int                checked = 0;

    always #5 clock = ~clock;

    rx_event_source src_u (.clock(clock), .frame_done(frame_done), .frame_len(frame_len),
        .crc_error(crc_error), .fcs_error(fcs_error));
    rx_statistics_counter_bank dut_u (.clock(clock), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .frame_done(frame_done), .frame_len(frame_len), .crc_error(crc_error),
        .fcs_error(fcs_error), .stats_paused(stats_paused));
    rx_statistics_counter_bank #(.ENABLE_RX_STATS(1'b0)) dut_off (.clock(clock), .rst_n(rst_n),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data_off),
        .frame_done(frame_done), .frame_len(frame_len), .crc_error(crc_error),
        .fcs_error(fcs_error), .stats_paused());

    task automatic chk(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] e);
        checked++;
        if (seen !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, e, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
        wr_data <= 32'($urandom);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
        w = rd_data_off;
    endtask

    // Two reads with no gap between the strobes; first answer in v, second in v2.
    task automatic rd_pair(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        #1;
        v = rd_data;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        v2 = rd_data;
    endtask

    // Returns {oversize, runt} hits for one frame of the given total length.
    function automatic logic [1:0] classify(input logic [LEN_W-1:0] len, input logic crc);
        return {crc && (len > OVERSIZE_LIMIT), crc && (len < RUNT_LIMIT)};
    endfunction

    task automatic traffic(input int n);
        logic [LEN_W-1:0] dlen;
        logic             crc;
        logic [1:0]       hit;
        int               k;
        for (int i = 0; i < n; i++) begin
            case ($urandom_range(0, 5))
                0: dlen = 16'h002f;
                1: dlen = 16'h0030;
                2: dlen = 16'h05de;
                3: dlen = 16'h05df;
                default: dlen = 16'($urandom_range(0, 1600));
            endcase
            crc = 1'($urandom);
            src_u.send_frame(dlen, crc);
            hit = classify(16'h000c + dlen + 16'h0004, crc);
            exp[IDX_RUNT] += 64'(hit[0]);
            exp[IDX_OVER] += 64'(hit[1]);
            if ($urandom_range(0, 1) == 1) begin
                k = $urandom_range(1, 3);
                src_u.pulse_fcs(k);
                exp[IDX_FCS] += 64'(k);
            end
        end
        repeat (3) @(posedge clock);
    endtask

    task automatic check_all(input string tname, input logic [CNT_W-1:0] e [NUM_CNT]);
        rd(ADDR_RUNT_LOW);
        chk("runt_low", v, e[IDX_RUNT][31:0]);
        chk("off_runt_low", w, 32'h0);
        rd(ADDR_RUNT_HIGH);
        chk("runt_high", v, e[IDX_RUNT][63:32]);
        chk("off_runt_high", w, 32'h0);
        rd(ADDR_OVER_LOW);
        chk("oversize_low", v, e[IDX_OVER][31:0]);
        chk("off_oversize_low", w, 32'h0);
        rd(ADDR_FCS_LOW);
        chk("fcs_low", v, e[IDX_FCS][31:0]);
        chk("off_fcs_low", w, 32'h0);
        $display("test %s done", tname);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        print_verdict();
    end

    initial begin
        void'($urandom(91551));
        foreach (exp[i]) exp[i] = 64'h0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        check_all("reset", exp);
        rd(12'h903);
        chk("unmapped", v, 32'h0);
        traffic(40);
        check_all("random", exp);
        check_all("reread", exp);
        wr(ADDR_RUNT_LOW, 32'hffffffff);
        check_all("write_ro", exp);
        wr(ADDR_CONTROL, 32'h4);
        snap = exp;
        traffic(12);
        check_all("frozen", snap);
        fork
            src_u.pulse_fcs(3);
            rd_pair(ADDR_FCS_LOW);
        join
        exp[IDX_FCS] += 64'h3;
        chk("pair_first", v, snap[IDX_FCS][31:0]);
        chk("pair_second", v2, snap[IDX_FCS][31:0]);
        @(posedge clock);
        #1;
        chk("read_idle", rd_data, READ_IDLE);
        rd(ADDR_STATUS);
        chk("status", v, 32'h2);
        rd(ADDR_CONTROL);
        chk("control", v, 32'h4);
        chk("paused_port", {31'h0, stats_paused}, 32'h1);
        wr(ADDR_CONTROL, 32'h0);
        repeat (2) @(posedge clock);
        check_all("release", exp);
        wr(ADDR_CONTROL, 32'h1);
        foreach (exp[i]) exp[i] = 64'h0;
        repeat (2) @(posedge clock);
        rd(ADDR_CONTROL);
        chk("clear_reads_zero", v, 32'h0);
        check_all("clear", exp);
        traffic(10);
        check_all("after_clear", exp);
        print_verdict();
    end
endmodule
`default_nettype wire
